/* File: core/level_ctl_pkg.sv */
// constants for the interrupt level control register bank
// assumes an 8-bit register port with a 16-bit byte address
package level_ctl_pkg;

   // register geometry
   localparam int DATA_W = 8;
   localparam int ADDR_W = 16;
   localparam int LEVEL_W = 2;
   localparam int NUM_SRC = 11;
   localparam int SRC_IDX_W = 4;

   // byte addresses of the five level registers
   localparam logic [15:0] ADDR_BANK_31 = 16'hf02b;
   localparam logic [15:0] ADDR_BANK_40 = 16'hf02c;
   localparam logic [15:0] ADDR_BANK_51 = 16'hf02f;
   localparam logic [15:0] ADDR_BANK_60 = 16'hf030;
   localparam logic [15:0] ADDR_BANK_61 = 16'hf031;

   // reset value, shared by every level register
   localparam logic [7:0] BANK_RESET = 8'h00;

   // writable bits of each register; all others read as zero
   localparam logic [7:0] MASK_BANK_31 = 8'h30;
   localparam logic [7:0] MASK_BANK_40 = 8'h0f;
   localparam logic [7:0] MASK_BANK_51 = 8'h0f;
   localparam logic [7:0] MASK_BANK_60 = 8'hff;
   localparam logic [7:0] MASK_BANK_61 = 8'hcc;

   // low bit of each level field inside its register
   localparam int FLD_31_A = 4;
   localparam int FLD_40_A = 0;
   localparam int FLD_40_B = 2;
   localparam int FLD_51_A = 0;
   localparam int FLD_51_B = 2;
   localparam int FLD_60_A = 0;
   localparam int FLD_60_B = 2;
   localparam int FLD_60_C = 4;
   localparam int FLD_60_D = 6;
   localparam int FLD_61_A = 2;
   localparam int FLD_61_B = 6;

   // level encodings: 00 is level 1 (lowest), 11 is level 4 (highest)
   localparam logic [1:0] LEVEL_1 = 2'h0;
   localparam logic [1:0] LEVEL_4 = 2'h3;

   // value read from an unmapped address
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

endpackage

/* File: core/level_arb_if.sv */
// signals between the level register bank and its priority resolver
// assumes both ends run on the same clock; the resolver is combinational
`timescale 1ns/1ns
interface level_arb_if #(
   parameter int NSRC = 11,
   parameter int IDXW = 4
);
   logic [NSRC-1:0] request;
   logic [2*NSRC-1:0] level;
   logic ctlEnable;
   logic winValid;
   logic [IDXW-1:0] winIdx;

   modport arbiter (
      input request,
      input level,
      input ctlEnable,
      output winValid,
      output winIdx
   );

   modport owner (
      output request,
      output level,
      output ctlEnable,
      input winValid,
      input winIdx
   );
endinterface

/* File: core/level_priority_resolver.sv */
// priority resolver for concurrent maskable requests
// assumes requests are held by their sources until served
`timescale 1ns/1ns
module level_priority_resolver #(
   parameter int NSRC = 11,
   parameter int IDXW = 4
) (
   level_arb_if.arbiter arb
);

   // scan from the highest index down so ties fall to the lowest source
   always_comb begin
      logic found;
      logic [1:0] best;
      logic [1:0] cur;
      logic [IDXW-1:0] idx;
      found = 1'h0;
      best = level_ctl_pkg::LEVEL_1;
      cur = level_ctl_pkg::LEVEL_1;
      idx = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         // with level control off every source counts as one level
         cur = arb.ctlEnable ? arb.level[2*i +: 2] : level_ctl_pkg::LEVEL_1;
         // higher code wins, equal code goes to lower index
         if (arb.request[i] && (!found || cur >= best)) begin
            found = 1'h1;
            best = cur;
            idx = IDXW'(i);
         end
      end
      arb.winValid = found;
      arb.winIdx = idx;
   end

endmodule

/* File: core/interrupt_level_control_regs.sv */
// interrupt level control register bank for eleven maskable sources
// assumes a single-cycle register port on clk and same-clock enable and
// request inputs; the other level registers live elsewhere
//
// Functional notes
// - each register holds source levels and feeds them to the resolver
// - registers writable only while global level control is enabled
// - writes while level control disabled are dropped, contents kept
// - reads while disabled return last held value or reset value
// - level code 00 lowest level 1 up to 11 highest level 4
// - first register: writable field bits 5:4 only
// - second register: writable fields bits 3:2 and 1:0
// - third register: writable fields bits 3:2 and 1:0
// - fourth register: four writable fields 7:6, 5:4, 3:2, 1:0
// - fifth register: writable fields bits 7:6 and 3:2
// - all registers are 8 bits wide and reset to zero
// - first register at f02b, second at f02c
// - third, fourth, fifth registers at f02f, f030, f031
// - enabled: highest level first, then lowest source number
// - disabled: lowest source number first, others stay pending
`timescale 1ns/1ns
module interrupt_level_control_regs #(
   parameter int NSRC = level_ctl_pkg::NUM_SRC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] addr,
   input wire logic [7:0] wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   input wire logic levelControlGlobalEnable,
   input wire logic [NSRC-1:0] sourceRequest,
   output logic [7:0] rdData,
   output logic [2*NSRC-1:0] sourceLevel,
   output logic grantValid,
   output logic [3:0] grantSource
);

   // all state of the bank in one record
   typedef struct packed {
      logic [7:0] bank31;
      logic [7:0] bank40;
      logic [7:0] bank51;
      logic [7:0] bank60;
      logic [7:0] bank61;
      logic [7:0] rdData;
      logic [2*NSRC-1:0] level;
      logic grantValid;
      logic [3:0] grantSource;
   } state_t;

   localparam state_t STATE_RESET = '{
      bank31: level_ctl_pkg::BANK_RESET,
      bank40: level_ctl_pkg::BANK_RESET,
      bank51: level_ctl_pkg::BANK_RESET,
      bank60: level_ctl_pkg::BANK_RESET,
      bank61: level_ctl_pkg::BANK_RESET,
      rdData: 8'h00,
      level: '0,
      grantValid: 1'h0,
      grantSource: 4'h0
   };

   state_t state;
   state_t next_state;

   logic [2*NSRC-1:0] liveLevel;
   logic writeOk;

   level_arb_if #(.NSRC(NSRC), .IDXW(level_ctl_pkg::SRC_IDX_W)) arbBus ();

   level_priority_resolver #(.NSRC(NSRC), .IDXW(level_ctl_pkg::SRC_IDX_W)) resolver (
      .arb(arbBus)
   );

   // write is taken only while level control is on
   assign writeOk = wrStb && levelControlGlobalEnable;

   // gather the level fields in source order, lowest source first
   assign liveLevel = {
      state.bank61[level_ctl_pkg::FLD_61_B +: 2],
      state.bank61[level_ctl_pkg::FLD_61_A +: 2],
      state.bank60[level_ctl_pkg::FLD_60_D +: 2],
      state.bank60[level_ctl_pkg::FLD_60_C +: 2],
      state.bank60[level_ctl_pkg::FLD_60_B +: 2],
      state.bank60[level_ctl_pkg::FLD_60_A +: 2],
      state.bank51[level_ctl_pkg::FLD_51_B +: 2],
      state.bank51[level_ctl_pkg::FLD_51_A +: 2],
      state.bank40[level_ctl_pkg::FLD_40_B +: 2],
      state.bank40[level_ctl_pkg::FLD_40_A +: 2],
      state.bank31[level_ctl_pkg::FLD_31_A +: 2]
   };

   // resolver sees live levels, the mode and the pending requests
   assign arbBus.request = sourceRequest;
   assign arbBus.level = liveLevel;
   assign arbBus.ctlEnable = levelControlGlobalEnable;

   // next state: register writes, read data, level and grant copies
   always_comb begin
      next_state = state;

      // masked writes keep read-only bits at zero
      if (writeOk) begin
         case (addr)
            level_ctl_pkg::ADDR_BANK_31: begin
               next_state.bank31 = wrData & level_ctl_pkg::MASK_BANK_31;
            end
            level_ctl_pkg::ADDR_BANK_40: begin
               next_state.bank40 = wrData & level_ctl_pkg::MASK_BANK_40;
            end
            level_ctl_pkg::ADDR_BANK_51: begin
               next_state.bank51 = wrData & level_ctl_pkg::MASK_BANK_51;
            end
            level_ctl_pkg::ADDR_BANK_60: begin
               next_state.bank60 = wrData & level_ctl_pkg::MASK_BANK_60;
            end
            level_ctl_pkg::ADDR_BANK_61: begin
               next_state.bank61 = wrData & level_ctl_pkg::MASK_BANK_61;
            end
            default: begin
               // unmapped write is ignored
            end
         endcase
      end

      // read returns held contents whatever the enable, since a
      // disabled bank never changed after its last enabled write
      if (rdStb) begin
         case (addr)
            level_ctl_pkg::ADDR_BANK_31: begin
               next_state.rdData = state.bank31 & level_ctl_pkg::MASK_BANK_31;
            end
            level_ctl_pkg::ADDR_BANK_40: begin
               next_state.rdData = state.bank40 & level_ctl_pkg::MASK_BANK_40;
            end
            level_ctl_pkg::ADDR_BANK_51: begin
               next_state.rdData = state.bank51 & level_ctl_pkg::MASK_BANK_51;
            end
            level_ctl_pkg::ADDR_BANK_60: begin
               next_state.rdData = state.bank60 & level_ctl_pkg::MASK_BANK_60;
            end
            level_ctl_pkg::ADDR_BANK_61: begin
               next_state.rdData = state.bank61 & level_ctl_pkg::MASK_BANK_61;
            end
            default: begin
               next_state.rdData = level_ctl_pkg::UNMAPPED_READ;
            end
         endcase
      end else begin
         // read data valid only in the cycle after the strobe
         next_state.rdData = 8'h00;
      end

      // levels follow the stored fields one cycle later
      next_state.level = liveLevel;

      // winner registered so outputs come from flops
      next_state.grantValid = arbBus.winValid;
      next_state.grantSource = arbBus.winIdx;
   end

   // whole bank clears to zero, placing every source at level 1
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= STATE_RESET;
      end else begin
         state <= next_state;
      end
   end

   // outputs straight from the state record
   assign rdData = state.rdData;
   assign sourceLevel = state.level;
   assign grantValid = state.grantValid;
   assign grantSource = state.grantSource;

endmodule

/* File: dv/interrupt_level_control_regs_properties.sv */
// concurrent checks on the level register bank ports
// assumes one clock domain and only the top module's plain ports
`timescale 1ns/1ns
module level_regs_checker #(
   parameter int NSRC = 11
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] addr,
   input wire logic [7:0] wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   input wire logic levelControlGlobalEnable,
   input wire logic [NSRC-1:0] sourceRequest,
   input wire logic [7:0] rdData,
   input wire logic [2*NSRC-1:0] sourceLevel,
   input wire logic grantValid,
   input wire logic [3:0] grantSource
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // reserved bits of each register read back as zero
   a_ro_31: assert property (rdStb && addr == 16'hf02b |=> (rdData & 8'hcf) == 8'h0)
      else $error("reserved bits set in first register");
   a_ro_40: assert property (rdStb && addr == 16'hf02c |=> (rdData & 8'hf0) == 8'h0)
      else $error("reserved bits set in second register");
   a_ro_51: assert property (rdStb && addr == 16'hf02f |=> (rdData & 8'hf0) == 8'h0)
      else $error("reserved bits set in third register");
   a_ro_61: assert property (rdStb && addr == 16'hf031 |=> (rdData & 8'h33) == 8'h0)
      else $error("reserved bits set in fifth register");
   a_gap_read_zero: assert property (rdStb && addr == 16'hf02d |=> rdData == 8'h0)
      else $error("gap address returned data");
   // lag of two edges: store, then the level port
   a_write_reaches_level: assert property (wrStb && levelControlGlobalEnable && addr == 16'hf030
      |=> ##1 sourceLevel[17:10] == $past(wrData, 2))
      else $error("written levels not presented");
   a_hold_disabled: assert property (!levelControlGlobalEnable |=> ##1 $stable(sourceLevel))
      else $error("levels changed while disabled");
   a_no_req_no_grant: assert property (sourceRequest == '0 |=> !grantValid && grantSource == 4'h0)
      else $error("grant without request");
   a_req_grant: assert property (|sourceRequest |=> grantValid)
      else $error("request not granted");
   a_low_index: assert property (!levelControlGlobalEnable && sourceRequest[1:0] == 2'b10
      |=> grantSource == 4'h1)
      else $error("disabled order not lowest index");
   c_read_disabled: cover property (rdStb && !levelControlGlobalEnable);
   c_write_disabled: cover property (wrStb && !levelControlGlobalEnable);
   c_grant_enabled: cover property (grantValid && levelControlGlobalEnable);
endmodule
bind interrupt_level_control_regs level_regs_checker #(.NSRC(NSRC)) chk (.clk, .rst_n, .addr,
   .wrData, .wrStb, .rdStb, .levelControlGlobalEnable, .sourceRequest, .rdData, .sourceLevel,
   .grantValid, .grantSource);

/* File: dv/irq_source_model.sv */
// request source model: raises requests and holds each until it is served
// assumes a registered grant from the bank on the same clock
`timescale 1ns/1ns
module irq_source_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [10:0] raise,
   input wire logic grantValid,
   input wire logic [3:0] grantSource,
   output logic [10:0] sourceRequest
);
   logic [10:0] served;
   // only the granted source drops; the rest stay pending
   assign served = grantValid ? (11'h001 << grantSource) : 11'h000;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sourceRequest <= 11'h000;
      end else begin
         sourceRequest <= (sourceRequest | raise) & ~served;
      end
   end
endmodule

/* File: dv/interrupt_level_control_regs_tb_top.sv */
// self-checking bench for the interrupt level register bank
// assumes a 20 MHz clock and the request source model beside the bank
`timescale 1ns/1ns
module interrupt_level_control_regs_tb_top;
   logic clk, rst_n, wrStb, rdStb, levelControlGlobalEnable, grantValid;
   logic [15:0] addr;
   logic [7:0] wrData, rdData;
   logic [10:0] sourceRequest, raise;
   logic [21:0] sourceLevel;
   logic [3:0] grantSource;
   int n_fail = 0;
   int comparisons = 0;
   interrupt_level_control_regs uut (.clk, .rst_n, .addr, .wrData, .wrStb, .rdStb,
      .levelControlGlobalEnable, .sourceRequest, .rdData, .sourceLevel, .grantValid, .grantSource);
   irq_source_model src (.clk, .rst_n, .raise, .grantValid, .grantSource, .sourceRequest);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic check(input logic [21:0] got, input logic [21:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      @(posedge clk);
      wrStb <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe edge
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge clk);
      rdStb <= 1'b0;
      #1 check({14'h0000, rdData}, {14'h0000, e});
   endtask
   task automatic t_masks();
      // enable moves only on a rising edge, like every other input
      @(posedge clk);
      levelControlGlobalEnable <= 1'h1;
      wr(16'hf02b, 8'hff);
      rd(16'hf02b, 8'h30);
      wr(16'hf02c, 8'hff);
      rd(16'hf02c, 8'h0f);
      wr(16'hf02f, 8'hff);
      rd(16'hf02f, 8'h0f);
      wr(16'hf030, 8'hff);
      rd(16'hf030, 8'hff);
      wr(16'hf031, 8'hff);
      rd(16'hf031, 8'hcc);
      wr(16'hf02d, 8'hff);
      rd(16'hf02d, 8'h00);
   endtask
   // writes dropped while disabled, reads still answer
   task automatic t_disabled();
      @(posedge clk);
      levelControlGlobalEnable <= 1'h0;
      wr(16'hf030, 8'h00);
      rd(16'hf030, 8'hff);
      check(sourceLevel, 22'h3fffff);
   endtask
   // levels written before any request is raised, as software must
   task automatic t_levels();
      @(posedge clk);
      levelControlGlobalEnable <= 1'h1;
      wr(16'hf02b, 8'h10);
      wr(16'hf02c, 8'h09);
      wr(16'hf02f, 8'h00);
      wr(16'hf030, 8'he4);
      wr(16'hf031, 8'h84);
      repeat (2) @(posedge clk);
      #1 check(sourceLevel, 22'h279025);
   endtask
   // each winner shows for two cycles; count distinct winners only
   task automatic t_order(input logic en, input int exp [11]);
      int k;
      logic [3:0] last;
      k = 0;
      last = 4'hf;
      @(posedge clk);
      levelControlGlobalEnable <= en;
      raise <= 11'h7ff;
      @(posedge clk);
      raise <= 11'h000;
      repeat (60) begin
         @(posedge clk);
         #1;
         if (grantValid === 1'b1 && grantSource !== last && k < 11) begin
            check({18'h00000, grantSource}, 22'(exp[k]));
            last = grantSource;
            k++;
         end
      end
      check(22'(k), 22'h00000b);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      addr = 16'h0000;
      wrData = 8'h00;
      wrStb = 1'b0;
      rdStb = 1'b0;
      levelControlGlobalEnable = 1'b0;
      raise = 11'h000;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd(16'hf02b, 8'h00);
      rd(16'hf031, 8'h00);
      t_masks();
      t_disabled();
      t_levels();
      t_order(1'b1, '{8, 2, 7, 10, 0, 1, 6, 9, 3, 4, 5});
      t_order(1'b0, '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10});
      report_and_stop();
   end
   // watchdog: the scenarios need well under a thousand cycles
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      $display("unexpected at %0t: watchdog expired", $time);
      report_and_stop();
   end
endmodule
